// >>> src/gpio_ports.sv
`timescale 1ns/1ps
`include "gpio_defines.svh"

module gpio_ports import gpio_pkg::*; #(
	parameter int CARRIER_HALF = `CARRIER_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd_latch,
	input wire logic sfr_rd_pin,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	input wire logic carrier_global_enable,
	input wire logic [7:0] periph_en0,
	input wire logic [7:0] periph_en1,
	input wire logic [7:0] periph_en2,
	input wire logic [7:0] periph_out0,
	input wire logic [7:0] periph_out1,
	input wire logic [7:0] periph_out2,
	input wire logic [7:0] pad_in0,
	input wire logic [7:0] pad_in1,
	input wire logic [7:0] pad_in2,
	output logic [7:0] pad_out0,
	output logic [7:0] pad_out1,
	output logic [7:0] pad_out2,
	output logic [7:0] pad_oe_n0,
	output logic [7:0] pad_oe_n1,
	output logic [7:0] pad_oe_n2,
	output logic [7:0] pad_pu0,
	output logic [7:0] pad_pu1,
	output logic [7:0] pad_pu2,
	output logic reset_pin_pu
);

	// ************************************************************
	// register state
	// ************************************************************
	logic [7:0] port0_data_reg; // bit latches of port 0
	logic [7:0] port1_data_reg; // bit latches of port 1
	logic [7:0] port2_data_reg; // bit latches of port 2
	logic [7:0] carrier_pin_select_reg; // carrier select bits
	logic [7:0] pullup_off_port0_reg; // pull-up disables port 0
	logic [7:0] pullup_off_port1_reg; // pull-up disables port 1
	logic [7:0] pullup_off_port2_reg; // port 2 and reset pin
	logic [7:0] pin0_sync; // synchronised pad levels
	logic [7:0] pin1_sync;
	logic [7:0] pin2_sync;
	logic carrier_wave; // raw 38 kHz square wave
	logic carrier_en_sync_meta; // global enable may be async
	logic carrier_en_reg;
	logic [7:0] mod0; // per-pin carrier on port 0
	logic [7:0] mod1; // per-pin carrier on port 1
	logic [7:0] drive0_next; // wanted pad levels
	logic [7:0] drive1_next;
	logic [7:0] drive2_next;
	logic [7:0] rdata_next;
	logic rvalid_next;
	sfr_req_t req; // bundled cpu strobes

	assign req = '{addr: sfr_addr, wdata: sfr_wdata, wr: sfr_wr,
		rd_latch: sfr_rd_latch, rd_pin: sfr_rd_pin};

	// ************************************************************
	// pad input synchronisers
	// ************************************************************
	pin_sync #(.W(8)) u_sync0 (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.d(pad_in0),
		.q(pin0_sync)
	);

	pin_sync #(.W(8)) u_sync1 (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.d(pad_in1),
		.q(pin1_sync)
	);

	pin_sync #(.W(8)) u_sync2 (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.d(pad_in2),
		.q(pin2_sync)
	);

	// ************************************************************
	// carrier source
	// ************************************************************
	// enable comes from a config bit elsewhere; sync it anyway
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			carrier_en_sync_meta <= 1'b0;
			carrier_en_reg <= 1'b0;
		end else if (ce) begin
			carrier_en_sync_meta <= carrier_global_enable;
			carrier_en_reg <= carrier_en_sync_meta;
		end
	end

	// counter only runs while modulation is wanted, saves power
	carrier_gen #(.HALF_CYCLES(CARRIER_HALF)) u_carrier (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.run(carrier_en_reg),
		.wave(carrier_wave)
	);

	// ************************************************************
	// cpu writes
	// ************************************************************
	// bit latches: d flip-flops loaded by the write strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port0_data_reg <= `PORT_DATA_RESET;
			port1_data_reg <= `PORT_DATA_RESET;
			port2_data_reg <= `PORT_DATA_RESET;
		end else if (ce && req.wr) begin
			unique case (req.addr)
				`ADDR_PORT0_DATA: port0_data_reg <= req.wdata;
				`ADDR_PORT1_DATA: port1_data_reg <= req.wdata;
				`ADDR_PORT2_DATA: port2_data_reg <= req.wdata;
				default: ; // other addresses belong to other blocks
			endcase
		end
	end

	// carrier select bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			carrier_pin_select_reg <= `CARRIER_SEL_RESET;
		end else if (ce && req.wr &&
			req.addr == `ADDR_CARRIER_PIN_SELECT) begin
			carrier_pin_select_reg <= req.wdata;
		end
	end

	// pull-up disable registers, cleared means pull-up on
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pullup_off_port0_reg <= `PULLUP_OFF_RESET;
			pullup_off_port1_reg <= `PULLUP_OFF_RESET;
			pullup_off_port2_reg <= `PULLUP_OFF_RESET;
		end else if (ce && req.wr) begin
			unique case (req.addr)
				`ADDR_PULLUP_OFF_PORT0: pullup_off_port0_reg <= req.wdata;
				`ADDR_PULLUP_OFF_PORT1: pullup_off_port1_reg <= req.wdata;
				// reserved bits are not stored at all
				`ADDR_PULLUP_OFF_PORT2: pullup_off_port2_reg <=
					req.wdata & `PULLUP_OFF_PORT2_MASK;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// cpu reads
	// ************************************************************
	// latch read and pin read differ only on the port registers
	always_comb begin
		rdata_next = 8'h00;
		rvalid_next = req.rd_latch | req.rd_pin;
		unique case (req.addr)
			`ADDR_PORT0_DATA:
				rdata_next = req.rd_pin ? pin0_sync
					: port0_data_reg;
			`ADDR_PORT1_DATA:
				rdata_next = req.rd_pin ? pin1_sync
					: port1_data_reg;
			`ADDR_PORT2_DATA:
				rdata_next = req.rd_pin ? pin2_sync
					: port2_data_reg;
			`ADDR_CARRIER_PIN_SELECT: rdata_next = carrier_pin_select_reg;
			`ADDR_PULLUP_OFF_PORT0: rdata_next = pullup_off_port0_reg;
			`ADDR_PULLUP_OFF_PORT1: rdata_next = pullup_off_port1_reg;
			`ADDR_PULLUP_OFF_PORT2:
				rdata_next = pullup_off_port2_reg;
			default: begin
				// unmapped: no valid, sfr_rdata keeps its last value, not ours to claim
				rdata_next = 8'h00;
				rvalid_next = 1'b0;
			end
		endcase
	end

	// read data registered, one cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
			sfr_rvalid <= 1'b0;
		end else if (ce) begin
			sfr_rvalid <= rvalid_next;
			if (rvalid_next) begin
				sfr_rdata <= rdata_next;
			end
		end
	end

	// ************************************************************
	// carrier routing onto the selected pins
	// ************************************************************
	// both the global enable and the pin's select bit are needed
	always_comb begin
		mod0 = 8'h00;
		mod1 = 8'h00;
		if (carrier_en_reg) begin
			mod1[6] = carrier_pin_select_reg[7];
			mod1[5] = carrier_pin_select_reg[6];
			mod1[4] = carrier_pin_select_reg[5];
			mod1[1] = carrier_pin_select_reg[4];
			mod0[2] = carrier_pin_select_reg[3];
			mod0[7] = carrier_pin_select_reg[2];
			mod0[5] = carrier_pin_select_reg[1];
			mod0[3] = carrier_pin_select_reg[0];
		end
	end

	// ************************************************************
	// output level selection
	// ************************************************************
	// peripheral owns the pin when enabled, else latch xor carrier on ports 0 and 1, latch alone on port 2
	always_comb begin
		drive0_next = (periph_en0 & periph_out0) |
			(~periph_en0 & (port0_data_reg ^
			(mod0 & {8{carrier_wave}})));
		drive1_next = (periph_en1 & periph_out1) |
			(~periph_en1 & (port1_data_reg ^
			(mod1 & {8{carrier_wave}})));
		drive2_next = (periph_en2 & periph_out2) |
			(~periph_en2 & port2_data_reg);
	end

	// ************************************************************
	// pad drivers
	// ************************************************************
	// quasi-bidirectional: only a low is actively driven; a high is
	// the weak pull-up or, with it off, high impedance
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pad_out0 <= 8'h00;
			pad_out1 <= 8'h00;
			pad_out2 <= 8'h00;
			pad_oe_n0 <= 8'hff;
			pad_oe_n1 <= 8'hff;
			pad_oe_n2 <= 8'hff;
		end else if (ce) begin
			pad_out0 <= 8'h00;
			pad_out1 <= 8'h00;
			pad_out2 <= 8'h00;
			pad_oe_n0 <= drive0_next;
			pad_oe_n1 <= drive1_next;
			pad_oe_n2 <= drive2_next;
		end
	end

	// weak pull-up enables, one per pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pad_pu0 <= 8'hff;
			pad_pu1 <= 8'hff;
			pad_pu2 <= 8'h07;
			reset_pin_pu <= 1'b1;
		end else if (ce) begin
			pad_pu0 <= ~pullup_off_port0_reg;
			pad_pu1 <= ~pullup_off_port1_reg;
			// only pins 2..0 of port 2 have a switchable pull-up
			pad_pu2 <= {5'h00, ~pullup_off_port2_reg[2:0]};
			reset_pin_pu <=
				~pullup_off_port2_reg[`PULLUP_OFF_RESET_PIN_BIT];
		end
	end

endmodule : gpio_ports

// >>> src/gpio_defines.svh
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ************************************************************
// register addresses on the special-function-register bus
// ************************************************************
`define ADDR_PORT0_DATA 8'h80
`define ADDR_PORT1_DATA 8'h90
`define ADDR_CARRIER_PIN_SELECT 8'h9f
`define ADDR_PORT2_DATA 8'ha0
`define ADDR_PULLUP_OFF_PORT0 8'hb2
`define ADDR_PULLUP_OFF_PORT1 8'hb3
`define ADDR_PULLUP_OFF_PORT2 8'hb4

// ************************************************************
// reset values and field layouts
// ************************************************************
`define PORT_DATA_RESET 8'hff
`define CARRIER_SEL_RESET 8'h00
`define PULLUP_OFF_RESET 8'h00
// implemented bits of the port 2 pull-up register: 5 and 2..0
`define PULLUP_OFF_PORT2_MASK 8'h27
`define PULLUP_OFF_RESET_PIN_BIT 5

// ************************************************************
// carrier timing
// ************************************************************
`define CLK_FREQ_HZ 250000000
`define CARRIER_FREQ_HZ 38000
// half period in clock cycles, rounded to nearest
`define CARRIER_HALF_CYCLES \
	((`CLK_FREQ_HZ + `CARRIER_FREQ_HZ) / (2 * `CARRIER_FREQ_HZ))

`endif

// >>> src/gpio_pkg.sv
package gpio_pkg;

	// ************************************************************
	// per-port pin bundle
	// ************************************************************
	typedef struct packed {
		logic [7:0] out; // level driven to the pad when enabled
		logic [7:0] oe_n; // low while the pad is driven low
		logic [7:0] pullup_en; // weak pull-up switched on
	} pad_ctrl_t;

	// cpu access strobes towards the port registers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr; // write-to-latch strobe
		logic rd_latch; // read latch strobe
		logic rd_pin; // read pin strobe
	} sfr_req_t;

endpackage : gpio_pkg

// >>> src/carrier_gen.sv
`timescale 1ns/1ps
`include "gpio_defines.svh"

// ************************************************************
// 38 kHz square wave from the system clock
// ************************************************************
module carrier_gen import gpio_pkg::*; #(
	parameter int HALF_CYCLES = `CARRIER_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic run,
	output logic wave
);

	localparam int CW = $clog2(HALF_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

	logic [CW-1:0] cnt_reg; // cycles into the current half period

	// toggle every half period, equal halves give 50% duty
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			wave <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				// idle low so a stopped carrier leaves pins untouched
				cnt_reg <= '0;
				wave <= 1'b0;
			end else if (cnt_reg == LAST) begin
				cnt_reg <= '0;
				wave <= ~wave;
			end else begin
				cnt_reg <= cnt_reg + CW'(1);
			end
		end
	end

endmodule : carrier_gen

// >>> src/pin_sync.sv
`timescale 1ns/1ps

// ************************************************************
// two-stage synchroniser for a group of pad inputs
// ************************************************************
module pin_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg; // first stage, read by q only

	// resets high to match idle pulled-up pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '1;
			q <= '1;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule : pin_sync

// >>> tb/gpio_ports_sva.sv
`timescale 1ns/1ps
// ****
// port-level checker
// ****
module gpio_ports_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd_latch,
	input wire logic sfr_rd_pin,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	input wire logic [7:0] periph_en0,
	input wire logic [7:0] periph_en1,
	input wire logic [7:0] periph_out1,
	input wire logic [7:0] pad_out0,
	input wire logic [7:0] pad_oe_n0,
	input wire logic [7:0] pad_oe_n1,
	input wire logic [7:0] pad_pu0,
	input wire logic [7:0] pad_pu2,
	input wire logic reset_pin_pu
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic mapped; // address hits a register
	logic rd_q; // read taken last edge
	assign mapped = sfr_addr inside {8'h80, 8'h90, 8'h9f, 8'ha0, 8'hb2,
		8'hb3, 8'hb4};
	// read request seen, for the valid pulse
	// the valid flop freezes with the clock enable, so must this copy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= 1'b0;
		end else if (ce) begin
			rd_q <= (sfr_rd_latch || sfr_rd_pin) && mapped;
		end
	end
	property p_pu2_upper;
		pad_pu2[7:3] == 5'h00;
	endproperty
	a_pu2_upper: assert property (p_pu2_upper)
		else $error("port 2 upper pull-ups on");
	property p_out_low;
		pad_out0 == 8'h00;
	endproperty
	a_out_low: assert property (p_out_low)
		else $error("pad drives high");
	property p_wr_oe;
		(ce && sfr_wr && sfr_addr == 8'h80 && periph_en0 == 8'h00) ##1
		(ce && !(sfr_wr && sfr_addr == 8'h80) && periph_en0 == 8'h00)
		|=> (pad_oe_n0 & 8'h53) == ($past(sfr_wdata, 2) & 8'h53);
	endproperty
	a_wr_oe: assert property (p_wr_oe)
		else $error("pad enable not from latch");
	property p_pu0;
		(ce && sfr_wr && sfr_addr == 8'hb2) ##1
		(ce && !(sfr_wr && sfr_addr == 8'hb2))
		|=> pad_pu0 == ~$past(sfr_wdata, 2);
	endproperty
	a_pu0: assert property (p_pu0)
		else $error("port 0 pull-up wrong");
	property p_pu2;
		(ce && sfr_wr && sfr_addr == 8'hb4) ##1
		(ce && !(sfr_wr && sfr_addr == 8'hb4))
		|=> ($past(sfr_wdata, 2) & 8'h27) ==
		{2'b00, ~reset_pin_pu, 2'b00, ~pad_pu2[2:0]};
	endproperty
	a_pu2: assert property (p_pu2)
		else $error("port 2 pull-up wrong");
	property p_periph;
		(ce && periph_en1 == 8'hff && $stable(periph_out1))[*2]
		|=> pad_oe_n1 == $past(periph_out1);
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral not in control");
	property p_rvalid;
		sfr_rvalid == rd_q;
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read valid misplaced");
	property p_rdata_hold;
		!sfr_rvalid |-> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved");
endmodule : gpio_ports_chk

bind gpio_ports gpio_ports_chk i_chk (.clk, .rstn, .ce, .sfr_addr,
	.sfr_wdata, .sfr_wr, .sfr_rd_latch, .sfr_rd_pin, .sfr_rdata,
	.sfr_rvalid, .periph_en0, .periph_en1, .periph_out1, .pad_out0,
	.pad_oe_n0, .pad_oe_n1, .pad_pu0, .pad_pu2, .reset_pin_pu);

// >>> tb/pad_model.sv
`timescale 1ns/1ps
// ****
// eight pads plus the devices on them
// ****
module pad_model (
	input wire logic clk,
	input wire logic [7:0] out,
	input wire logic [7:0] oe_n,
	input wire logic [7:0] pu,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] level
);
	logic [7:0] float_reg = 8'h55; // undriven pads wander
	// flips each cycle so a floating pad never reads steady
	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	// chip sink wins, then device, then weak pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!oe_n[i]) level[i] = out[i];
			else if (ext_en[i]) level[i] = ext_val[i];
			else if (pu[i]) level[i] = 1'b1;
			else level[i] = float_reg[i];
		end
	end
endmodule : pad_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import gpio_pkg::*; ;
	localparam int HALF = 4; // short carrier half period
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic glob = 1'b0;
	sfr_req_t req = '0;
	logic [2:0][7:0] pen = '0;
	logic [2:0][7:0] pout = '0;
	logic [2:0][7:0] xen = '0;
	logic [2:0][7:0] xval = '0;
	wire [2:0][7:0] pin, pdo, oen, pu;
	logic [7:0] rdata;
	logic rvalid, rst_pu;
	int err_total = 0;
	int num_checks = 0;
	initial begin
		forever #2 clk = ~clk;
	end
	gpio_ports #(.CARRIER_HALF(HALF)) i_dut (.clk(clk), .rstn(rstn), .ce(ce),
		.sfr_addr(req.addr), .sfr_wdata(req.wdata), .sfr_wr(req.wr),
		.sfr_rd_latch(req.rd_latch), .sfr_rd_pin(req.rd_pin),
		.sfr_rdata(rdata), .sfr_rvalid(rvalid),
		.carrier_global_enable(glob), .periph_en0(pen[0]),
		.periph_en1(pen[1]), .periph_en2(pen[2]), .periph_out0(pout[0]),
		.periph_out1(pout[1]), .periph_out2(pout[2]), .pad_in0(pin[0]),
		.pad_in1(pin[1]), .pad_in2(pin[2]), .pad_out0(pdo[0]),
		.pad_out1(pdo[1]), .pad_out2(pdo[2]), .pad_oe_n0(oen[0]),
		.pad_oe_n1(oen[1]), .pad_oe_n2(oen[2]), .pad_pu0(pu[0]),
		.pad_pu1(pu[1]), .pad_pu2(pu[2]), .reset_pin_pu(rst_pu));
	for (genvar g = 0; g < 3; g++) begin : g_pad
		pad_model i_pad (.clk(clk), .out(pdo[g]), .oe_n(oen[g]), .pu(pu[g]),
			.ext_en(xen[g]), .ext_val(xval[g]), .level(pin[g]));
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		tick(1);
		req.wr = 1'b0;
		// one idle edge so a following request never re-raises at once
		tick(1);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic p,
		input logic [7:0] e, input logic v);
		req.addr = a;
		req.rd_pin = p;
		req.rd_latch = ~p;
		tick(1);
		// valid stands for one cycle only: judge it right after the take
		chk({7'h00, rvalid}, {7'h00, v});
		chk(rdata, e);
		req.rd_pin = 1'b0;
		req.rd_latch = 1'b0;
		tick(1);
	endtask : rd_chk
	task automatic watch(output logic [7:0] c0, output logic [7:0] c1,
		output int n);
		logic [7:0] p0, p1;
		c0 = 8'h00;
		c1 = 8'h00;
		n = 0;
		p0 = oen[0];
		p1 = oen[1];
		repeat (40) begin
			tick(1);
			c0 |= oen[0] ^ p0;
			c1 |= oen[1] ^ p1;
			if (oen[0] != p0 || oen[1] != p1) n++;
			p0 = oen[0];
			p1 = oen[1];
		end
	endtask : watch
	task automatic s_reset;
		logic [7:0] a [7] = '{8'h80, 8'h90, 8'h9f, 8'ha0, 8'hb2, 8'hb3, 8'hb4};
		logic [7:0] e [7] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
		chk(oen[0] & oen[1], 8'hff);
		chk(pu[0] & pu[1], 8'hff);
		chk({pu[2][6:0], rst_pu}, 8'h0f);
		for (int i = 0; i < 7; i++) begin
			rd_chk(a[i], 1'b0, e[i], 1'b1);
		end
		rd_chk(8'h81, 1'b0, 8'h00, 1'b0);
	endtask : s_reset
	task automatic s_pins;
		wr(8'h80, 8'hff);
		xen[0] = 8'hff;
		xval[0] = 8'h5a;
		tick(3);
		rd_chk(8'h80, 1'b1, 8'h5a, 1'b1);
		rd_chk(8'h80, 1'b0, 8'hff, 1'b1);
		xen[0] = 8'h00;
		ce = 1'b0;
		wr(8'h80, 8'h00);
		ce = 1'b1;
		rd_chk(8'h80, 1'b0, 8'hff, 1'b1);
		wr(8'h90, 8'h0f);
		tick(2);
		chk(oen[1], 8'h0f);
		tick(1);
		rd_chk(8'h90, 1'b1, 8'h0f, 1'b1);
	endtask : s_pins
	task automatic s_open;
		wr(8'hb3, 8'hf0);
		tick(2);
		chk(pu[1], 8'h0f);
		chk(oen[1], 8'h0f);
		wr(8'h90, 8'hff);
		chk(oen[1], 8'hff);
		wr(8'hb2, 8'h3c);
		chk(pu[0], 8'hc3);
		wr(8'hb2, 8'h00);
		wr(8'hb4, 8'hff);
		rd_chk(8'hb4, 1'b0, 8'h27, 1'b1);
		chk({pu[2][6:0], rst_pu}, 8'h00);
		wr(8'hb4, 8'h00);
		wr(8'hb3, 8'h00);
	endtask : s_open
	task automatic s_carrier;
		logic [7:0] m0 [8] = '{8'h08, 8'h20, 8'h80, 8'h04, 8'h00, 8'h00,
			8'h00, 8'h00};
		logic [7:0] m1 [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h10,
			8'h20, 8'h40};
		logic [7:0] c0, c1;
		int n;
		wr(8'h90, 8'hff);
		wr(8'h9f, 8'hff);
		watch(c0, c1, n);
		chk(c0 | c1, 8'h00);
		glob = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(8'h9f, 8'h01 << i);
			tick(4);
			watch(c0, c1, n);
			chk(c0, m0[i]);
			chk(c1, m1[i]);
			chk(n[7:0], 8'h0a);
		end
		glob = 1'b0;
		tick(4);
		watch(c0, c1, n);
		chk(c0 | c1, 8'h00);
		wr(8'h9f, 8'h00);
	endtask : s_carrier
	task automatic s_periph;
		pen = {8'hff, 8'hff, 8'hff};
		pout = {8'h05, 8'h81, 8'h3c};
		tick(3);
		chk(oen[0], 8'h3c);
		chk(oen[1], 8'h81);
		chk(oen[2] & 8'h07, 8'h05);
		chk(pdo[0] | pdo[1] | pdo[2], 8'h00);
		pen = '0;
		tick(2);
	endtask : s_periph
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		tick(3);
		rstn = 1'b1;
		s_reset();
		s_pins();
		s_open();
		s_carrier();
		s_periph();
		wr(8'h80, 8'h00);
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
		s_reset();
		tally_and_finish();
	end
endmodule : tb_top
